// ---- verilog/bq_consts.svh ----
// Shared constants of the burst-of-four double-rate SRAM port
`ifndef BQ_CONSTS_SVH
`define BQ_CONSTS_SVH
`define BQ_WORD_W 18
`define BQ_LANE_W 9
`define BQ_ADDR_W 17
`define BQ_BURST_W 2
`define BQ_BURST_LEN 4
`define BQ_CLK_NS 20
`define BQ_K_PERIOD_NS 160
`define BQ_HALF_CYC ((`BQ_K_PERIOD_NS) / (2 * `BQ_CLK_NS))
`define BQ_WR_SKIP 2
`endif

// ---- verilog/bq_pkg.sv ----
// Types of the burst-of-four double-rate SRAM port
`include "bq_consts.svh"
package bq_pkg;
	typedef logic [`BQ_WORD_W-1:0] bq_word_type;
	typedef logic [`BQ_ADDR_W-1:0] bq_addr_type;
	typedef logic [`BQ_BURST_W-1:0] bq_idx_type;
	typedef logic [1:0] bq_lanes_type;
	typedef enum logic [1:0] {
		BQ_RD_IDLE = 2'h0,
		BQ_RD_ARM = 2'h1,
		BQ_RD_SEND = 2'h3
	} bq_rd_state_type;
endpackage

// ---- verilog/bq_link_if.sv ----
// Pin bundle between memory controller and SRAM device
`timescale 1ns/10ps
`include "bq_consts.svh"
interface bq_link_if;
	logic k;
	logic k_n;
	logic c;
	logic c_n;
	logic rd_sel_n;
	logic wr_sel_n;
	logic [`BQ_ADDR_W-1:0] burst_address_bus;
	logic byte_lane_low_write_enable_n;
	logic byte_lane_high_write_enable_n;
	logic [`BQ_WORD_W-1:0] d;
	logic [`BQ_WORD_W-1:0] q;
	logic q_oe;
	modport dev (
		input k, k_n, c, c_n, rd_sel_n, wr_sel_n, burst_address_bus,
		input byte_lane_low_write_enable_n, byte_lane_high_write_enable_n, d,
		output q, q_oe
	);
	modport ctl (
		output k, k_n, c, c_n, rd_sel_n, wr_sel_n, burst_address_bus,
		output byte_lane_low_write_enable_n, byte_lane_high_write_enable_n, d,
		input q, q_oe
	);
endinterface

// ---- verilog/bq_sram_ctl.sv ----
// Memory controller end: makes the clocks, issues bursts, collects read words
`timescale 1ns/10ps
`include "bq_consts.svh"
module bq_sram_ctl (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	// Link to the device
	bq_link_if.ctl link,
	// Static mode: hold output clocks high
	input wire logic single_clk,
	// Requests
	input wire logic req_rd,
	input wire logic req_wr,
	input wire logic [`BQ_ADDR_W-1:0] req_addr,
	input wire logic [4*`BQ_WORD_W-1:0] req_wdata,
	input wire logic [7:0] req_bw_n,
	output logic req_ack,
	// Read answers
	output logic [4*`BQ_WORD_W-1:0] rd_data,
	output logic rd_valid
);
	localparam logic [2:0] HALF = 3'(`BQ_HALF_CYC);
	localparam logic [2:0] LAST = 3'(2 * `BQ_HALF_CYC - 1);
	localparam logic [2:0] QTR = 3'(`BQ_HALF_CYC / 2);

	logic [2:0] ph_ff;
	logic [2:0] nxt_ph;
	logic k_ff, kn_ff, c_ff, cn_ff;
	logic rsel_n_ff, wsel_n_ff, rd_gap_ff, wr_gap_ff, ack_ff;
	bq_pkg::bq_addr_type addr_ff;
	bq_pkg::bq_word_type d_ff;
	logic [1:0] bw_n_ff;
	logic [4*`BQ_WORD_W-1:0] wsh_ff;
	logic [7:0] wbw_ff;
	logic [2:0] wleft_ff;
	logic [4*`BQ_WORD_W-1:0] whold_ff, wsrc;
	logic [7:0] whold_bw_ff, wsrc_bw;
	logic wpend_ff;
	logic [1:0] wskip_ff;
	logic [`BQ_WORD_W:0] qs1_ff, qs2_ff;
	logic [4*`BQ_WORD_W-1:0] rsh_ff, rd_data_ff;
	bq_pkg::bq_idx_type rcnt_ff;
	logic rd_valid_ff;
	logic slot, quarter, sample;

	assign nxt_ph = (ph_ff == LAST) ? 3'h0 : ph_ff + 3'h1;
	// Command slot sits mid-period so it is stable at the next K rise
	assign slot = ce && (nxt_ph == HALF);
	assign quarter = ce && (nxt_ph == QTR || nxt_ph == (HALF + QTR));
	assign sample = ce && (nxt_ph == (HALF - 3'h1) || nxt_ph == LAST);

	// ==========================================================
	// Clock divider
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			// Last phase, so the first K high after reset is a full half period
			ph_ff <= LAST;
			k_ff <= 1'h0;
			kn_ff <= 1'h1;
			c_ff <= 1'h0;
			cn_ff <= 1'h1;
		end else if (ce) begin
			ph_ff <= nxt_ph;
			k_ff <= (nxt_ph < HALF);
			kn_ff <= !(nxt_ph < HALF);
			// output pair held static high in single mode
			c_ff <= single_clk || (nxt_ph < HALF);
			cn_ff <= single_clk || !(nxt_ph < HALF);
		end
	end
	assign link.k = k_ff;
	assign link.k_n = kn_ff;
	assign link.c = c_ff;
	assign link.c_n = cn_ff;

	// ==========================================================
	// Command issue, one burst per port every second K edge
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rsel_n_ff <= 1'h1;
			wsel_n_ff <= 1'h1;
			rd_gap_ff <= 1'h0;
			wr_gap_ff <= 1'h0;
			ack_ff <= 1'h0;
			addr_ff <= '0;
		end else if (ce) begin
			ack_ff <= 1'h0;
			if (slot) begin
				rsel_n_ff <= 1'h1;
				wsel_n_ff <= 1'h1;
				rd_gap_ff <= 1'h0;
				wr_gap_ff <= 1'h0;
				if (req_rd && !rd_gap_ff) begin
					rsel_n_ff <= 1'h0;
					rd_gap_ff <= 1'h1;
					addr_ff <= req_addr;
					ack_ff <= 1'h1;
				end else if (req_wr && !wr_gap_ff) begin
					wsel_n_ff <= 1'h0;
					wr_gap_ff <= 1'h1;
					addr_ff <= req_addr;
					ack_ff <= 1'h1;
				end
			end
		end
	end

	// ==========================================================
	// Write data, one word per half period
	assign wsrc = (wleft_ff != 3'h0) ? wsh_ff : whold_ff;
	assign wsrc_bw = (wleft_ff != 3'h0) ? wbw_ff : whold_bw_ff;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wsh_ff <= '0;
			wbw_ff <= 8'hFF;
			whold_ff <= '0;
			whold_bw_ff <= 8'hFF;
			wpend_ff <= 1'h0;
			wleft_ff <= 3'h0;
			wskip_ff <= 2'h0;
			d_ff <= '0;
			bw_n_ff <= 2'h3;
		end else if (ce) begin
			if (slot && !(req_rd && !rd_gap_ff) && req_wr && !wr_gap_ff) begin
				// Held apart from the shifter so a burst still going out is not cut
				whold_ff <= req_wdata;
				whold_bw_ff <= req_bw_n;
				wpend_ff <= 1'h1;
				wskip_ff <= 2'(`BQ_WR_SKIP);
			end else if (quarter) begin
				// first word one period after the command edge
				if (wskip_ff != 2'h0) begin
					wskip_ff <= wskip_ff - 2'h1;
				end
				if (wleft_ff != 3'h0 || (wpend_ff && wskip_ff == 2'h0)) begin
					// lane enables travel with each word
					d_ff <= wsrc[`BQ_WORD_W-1:0];
					bw_n_ff <= wsrc_bw[1:0];
					wsh_ff <= {{`BQ_WORD_W{1'h0}}, wsrc[4*`BQ_WORD_W-1:`BQ_WORD_W]};
					wbw_ff <= {2'h3, wsrc_bw[7:2]};
					if (wleft_ff != 3'h0) begin
						wleft_ff <= wleft_ff - 3'h1;
					end else begin
						wleft_ff <= 3'(`BQ_BURST_LEN - 1);
						wpend_ff <= 1'h0;
					end
				end else begin
					bw_n_ff <= 2'h3;
				end
			end
		end
	end
	assign link.rd_sel_n = rsel_n_ff;
	assign link.wr_sel_n = wsel_n_ff;
	assign link.burst_address_bus = addr_ff;
	assign link.d = d_ff;
	assign link.byte_lane_low_write_enable_n = bw_n_ff[0];
	assign link.byte_lane_high_write_enable_n = bw_n_ff[1];

	// ==========================================================
	// Read collection
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			qs1_ff <= '0;
			qs2_ff <= '0;
		end else if (ce) begin
			qs1_ff <= {link.q_oe, link.q};
			qs2_ff <= qs1_ff;
		end
	end
	// four words make one answer, first word lowest
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rsh_ff <= '0;
			rcnt_ff <= 2'h0;
			rd_data_ff <= '0;
			rd_valid_ff <= 1'h0;
		end else if (ce) begin
			rd_valid_ff <= 1'h0;
			if (sample && qs2_ff[`BQ_WORD_W]) begin
				rsh_ff <= {qs2_ff[`BQ_WORD_W-1:0], rsh_ff[4*`BQ_WORD_W-1:`BQ_WORD_W]};
				rcnt_ff <= rcnt_ff + 2'h1;
				if (rcnt_ff == 2'h3) begin
					rd_data_ff <= {qs2_ff[`BQ_WORD_W-1:0], rsh_ff[4*`BQ_WORD_W-1:`BQ_WORD_W]};
					rd_valid_ff <= 1'h1;
				end
			end
		end
	end
	assign req_ack = ack_ff;
	assign rd_data = rd_data_ff;
	assign rd_valid = rd_valid_ff;
endmodule

// ---- verilog/bq_sram_dev.sv ----
// SRAM device end: burst-of-four double-rate read and write ports
// Summary of operation
// - Address taken only on K rise starting transaction
// - Each burst moves four 18-bit words
// - Address ignored when no port selected
// - Read select starts read, ignored next edge
// - Write select starts write, ignored next edge
// - Both selects: read only, write dropped, unless read select is being ignored
// - Byte stored only when enabled during write
// - Low lane bits 0-8, high 9-17
// - Commands on K; data on K and K#
// - Controller drives K# half period from K
// - Words 2,4 on C; 1,3 on C#
// - Both output clocks high: use K pair
// - Single-clock mode pins stay static
// - Write words start one period after command
// - Read data after the next K rise
// - Read bus released when not delivering
// - Read after write forwards write register
`timescale 1ns/10ps
`include "bq_consts.svh"
module bq_sram_dev (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	// Link to the controller
	bq_link_if.dev link,
	// Status
	output logic rd_busy,
	output logic wr_busy,
	output logic single_clk_mode
);
	localparam int D_LO = 0;
	localparam int BW_LO = `BQ_WORD_W;
	localparam int A_LO = BW_LO + 2;
	localparam int W_POS = A_LO + `BQ_ADDR_W;
	localparam int R_POS = W_POS + 1;
	localparam int CN_POS = R_POS + 1;
	localparam int C_POS = CN_POS + 1;
	localparam int KN_POS = C_POS + 1;
	localparam int K_POS = KN_POS + 1;
	localparam int PW = K_POS + 1;
	localparam int MW = `BQ_ADDR_W + `BQ_BURST_W;
	// Pin levels while the controller is held in reset
	localparam logic [PW-1:0] PIN_IDLE = {1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1,
		{`BQ_ADDR_W{1'h0}}, 2'h3, {`BQ_WORD_W{1'h0}}};

	// ==========================================================
	// Storage
	bq_pkg::bq_word_type mem [0:(1 << MW)-1];

	// low lane governs bits 0-8, high lane bits 9-17
	function automatic bq_pkg::bq_word_type merge(
		input bq_pkg::bq_word_type old_w,
		input bq_pkg::bq_word_type new_w,
		input bq_pkg::bq_lanes_type bw_n
	);
		bq_pkg::bq_word_type r;
		r = old_w;
		if (!bw_n[0]) begin
			r[`BQ_LANE_W-1:0] = new_w[`BQ_LANE_W-1:0];
		end
		if (!bw_n[1]) begin
			r[`BQ_WORD_W-1:`BQ_LANE_W] = new_w[`BQ_WORD_W-1:`BQ_LANE_W];
		end
		return r;
	endfunction

	// ==========================================================
	// Pin synchroniser and edge finding
	logic [PW-1:0] pins;
	logic [PW-1:0] s1_ff, s2_ff;
	logic [3:0] clk_prev_ff;
	logic k_rise, kn_rise, c_rise, cn_rise, single, out_a, out_b;
	logic r_n, w_n;
	bq_pkg::bq_addr_type pin_addr;
	bq_pkg::bq_word_type pin_d;
	bq_pkg::bq_lanes_type pin_bw;

	assign pins = {link.k, link.k_n, link.c, link.c_n, link.rd_sel_n, link.wr_sel_n,
		link.burst_address_bus, link.byte_lane_high_write_enable_n,
		link.byte_lane_low_write_enable_n, link.d};

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			// Idle levels, so no false clock edge is found after reset
			s1_ff <= PIN_IDLE;
			s2_ff <= PIN_IDLE;
			clk_prev_ff <= 4'h5;
		end else if (ce) begin
			s1_ff <= pins;
			s2_ff <= s1_ff;
			clk_prev_ff <= s2_ff[K_POS:CN_POS];
		end
	end

	assign k_rise = s2_ff[K_POS] & ~clk_prev_ff[3];
	assign kn_rise = s2_ff[KN_POS] & ~clk_prev_ff[2];
	assign c_rise = s2_ff[C_POS] & ~clk_prev_ff[1];
	assign cn_rise = s2_ff[CN_POS] & ~clk_prev_ff[0];
	assign r_n = s2_ff[R_POS];
	assign w_n = s2_ff[W_POS];
	assign pin_addr = s2_ff[W_POS-1:A_LO];
	assign pin_bw = s2_ff[A_LO-1:BW_LO];
	assign pin_d = s2_ff[BW_LO-1:D_LO];
	// both output clocks high selects the input pair
	assign single = s2_ff[C_POS] & s2_ff[CN_POS];
	// even-index words on C#, odd-index words on C
	assign out_a = single ? kn_rise : cn_rise;
	assign out_b = single ? k_rise : c_rise;

	// ==========================================================
	// Command decode
	logic rd_ign_ff, wr_ign_ff;
	logic rd_start, wr_start;

	// read select honoured unless just used
	assign rd_start = ce && k_rise && !r_n && !rd_ign_ff;
	// read wins over a simultaneous write
	assign wr_start = ce && k_rise && !w_n && !wr_ign_ff && !rd_start;

	// selects seen on K rise only
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rd_ign_ff <= 1'h0;
			wr_ign_ff <= 1'h0;
		end else if (ce && k_rise) begin
			rd_ign_ff <= rd_start;
			// write select ignored on the next K edge
			wr_ign_ff <= wr_start;
		end
	end

	// ==========================================================
	// Write register
	logic wr_busy_ff, wr_nxt_ff;
	bq_pkg::bq_addr_type wr_addr_ff, wr_nxt_addr_ff;
	bq_pkg::bq_idx_type wr_idx_ff;
	bq_pkg::bq_word_type wr_word_ff [0:3];
	bq_pkg::bq_lanes_type wr_bw_ff [0:3];
	logic [3:0] wr_got_ff;
	logic wr_cap;

	// data words on both K and K# rises
	assign wr_cap = ce && wr_busy_ff && (wr_idx_ff[0] ? kn_rise : k_rise);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wr_busy_ff <= 1'h0;
			wr_nxt_ff <= 1'h0;
			wr_addr_ff <= '0;
			wr_nxt_addr_ff <= '0;
			wr_idx_ff <= 2'h0;
			wr_got_ff <= 4'h0;
		end else if (ce) begin
			if (wr_cap) begin
				wr_got_ff[wr_idx_ff] <= 1'h1;
				wr_idx_ff <= wr_idx_ff + 2'h1;
				if (wr_idx_ff == 2'h3) begin
					wr_got_ff <= 4'h0;
					wr_busy_ff <= wr_nxt_ff;
					wr_addr_ff <= wr_nxt_addr_ff;
					wr_nxt_ff <= 1'h0;
				end
			end
			// address taken only when a burst starts
			if (wr_start) begin
				if (wr_busy_ff) begin
					wr_nxt_ff <= 1'h1;
					wr_nxt_addr_ff <= pin_addr;
				end else begin
					wr_busy_ff <= 1'h1;
					wr_addr_ff <= pin_addr;
					wr_idx_ff <= 2'h0;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (wr_cap) begin
			wr_word_ff[wr_idx_ff] <= pin_d;
			wr_bw_ff[wr_idx_ff] <= pin_bw;
		end
	end

	// commit lanes enabled, after the fourth word
	always_ff @(posedge clk_sys) begin
		if (wr_cap && wr_idx_ff == 2'h3) begin
			for (int j = 0; j < 3; j++) begin
				mem[{wr_addr_ff, 2'(j)}] <= merge(mem[{wr_addr_ff, 2'(j)}], wr_word_ff[j],
					wr_bw_ff[j]);
			end
			mem[{wr_addr_ff, 2'h3}] <= merge(mem[{wr_addr_ff, 2'h3}], pin_d, pin_bw);
		end
	end

	// ==========================================================
	// Read engine
	bq_pkg::bq_rd_state_type rd_state_ff;
	logic rd_nxt_ff;
	bq_pkg::bq_addr_type rd_addr_ff, rd_nxt_addr_ff;
	bq_pkg::bq_idx_type rd_idx_ff;
	logic rd_launch;
	bq_pkg::bq_word_type rd_word;

	assign rd_launch = ce && (rd_state_ff == bq_pkg::BQ_RD_SEND) &&
		(rd_idx_ff[0] ? out_b : out_a);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rd_state_ff <= bq_pkg::BQ_RD_IDLE;
			rd_nxt_ff <= 1'h0;
			rd_addr_ff <= '0;
			rd_nxt_addr_ff <= '0;
			rd_idx_ff <= 2'h0;
		end else if (ce) begin
			case (rd_state_ff)
				bq_pkg::BQ_RD_IDLE: begin
					// address only looked at on a started burst
					if (rd_start) begin
						rd_state_ff <= bq_pkg::BQ_RD_ARM;
						rd_addr_ff <= pin_addr;
					end
				end
				bq_pkg::BQ_RD_ARM: begin
					// delivery begins after the next K rise
					if (k_rise) begin
						rd_state_ff <= bq_pkg::BQ_RD_SEND;
						rd_idx_ff <= 2'h0;
					end
				end
				bq_pkg::BQ_RD_SEND: begin
					if (rd_start) begin
						rd_nxt_ff <= 1'h1;
						rd_nxt_addr_ff <= pin_addr;
					end
					if (rd_launch) begin
						// burst counter appended, 0 to 3
						rd_idx_ff <= rd_idx_ff + 2'h1;
						if (rd_idx_ff == 2'h3) begin
							rd_nxt_ff <= 1'h0;
							rd_addr_ff <= rd_nxt_addr_ff;
							rd_state_ff <= (rd_nxt_ff || rd_start) ? bq_pkg::BQ_RD_SEND :
								bq_pkg::BQ_RD_IDLE;
							if (rd_start) begin
								rd_addr_ff <= pin_addr;
							end
						end
					end
				end
				default: begin
					rd_state_ff <= bq_pkg::BQ_RD_IDLE;
				end
			endcase
		end
	end

	// pending write words take precedence over the array
	always_comb begin
		rd_word = mem[{rd_addr_ff, rd_idx_ff}];
		if (wr_busy_ff && wr_addr_ff == rd_addr_ff && wr_got_ff[rd_idx_ff]) begin
			rd_word = merge(rd_word, wr_word_ff[rd_idx_ff], wr_bw_ff[rd_idx_ff]);
		end
	end

	// ==========================================================
	// Output register
	bq_pkg::bq_word_type q_ff;
	logic q_oe_ff;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			q_ff <= '0;
			q_oe_ff <= 1'h0;
		end else if (ce) begin
			if (rd_launch) begin
				q_ff <= rd_word;
				q_oe_ff <= 1'h1;
			end else if ((out_a || out_b) && rd_state_ff != bq_pkg::BQ_RD_SEND) begin
				// release the bus once the last word has stood
				q_oe_ff <= 1'h0;
			end
		end
	end
	assign link.q = q_ff;
	assign link.q_oe = q_oe_ff;

	// ==========================================================
	// Status
	logic rd_busy_ff, wr_busy_o_ff, single_ff;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rd_busy_ff <= 1'h0;
			wr_busy_o_ff <= 1'h0;
			single_ff <= 1'h0;
		end else if (ce) begin
			rd_busy_ff <= (rd_state_ff != bq_pkg::BQ_RD_IDLE);
			wr_busy_o_ff <= wr_busy_ff;
			single_ff <= single;
		end
	end
	assign rd_busy = rd_busy_ff;
	assign wr_busy = wr_busy_o_ff;
	assign single_clk_mode = single_ff;
endmodule

// ---- sim/bq_link_asserts.sv ----
// Checker of the link between the controller end and the SRAM device end
`timescale 1ns/10ps
`include "bq_consts.svh"
module bq_link_asserts (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Link pins
	input wire logic k,
	input wire logic k_n,
	input wire logic c,
	input wire logic c_n,
	input wire logic rd_sel_n,
	input wire logic wr_sel_n,
	input wire logic [`BQ_ADDR_W-1:0] burst_address_bus,
	input wire logic byte_lane_low_write_enable_n,
	input wire logic byte_lane_high_write_enable_n,
	input wire logic [`BQ_WORD_W-1:0] d,
	input wire logic [`BQ_WORD_W-1:0] q,
	input wire logic q_oe
);
	logic [5:0] since_rd_ff;
	logic [5:0] since_wr_ff;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	// ==========================================
	// Cycles since a select was seen, saturating
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			since_rd_ff <= 6'h3F;
		end else if (!rd_sel_n) begin
			since_rd_ff <= 6'h00;
		end else if (since_rd_ff != 6'h3F) begin
			since_rd_ff <= since_rd_ff + 6'h01;
		end
	end
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			since_wr_ff <= 6'h3F;
		end else if (!wr_sel_n) begin
			since_wr_ff <= 6'h00;
		end else if (since_wr_ff != 6'h3F) begin
			since_wr_ff <= since_wr_ff + 6'h01;
		end
	end
	// ==========================================
	// Sequences
	sequence s_k_cycle;
		k [*4] ##1 !k [*4];
	endsequence
	// Held one K period, then skipped for one slot
	sequence s_sel_frame(sel);
		!sel [*8] ##1 sel [*8];
	endsequence
	sequence s_burst;
		q_oe [*8] ##1 q_oe [*8];
	endsequence
	// ==========================================
	// Assertions
	k_inverse_a: assert property (k_n == !k)
		else $error("k_n is not the inverse of k");
	out_clk_a: assert property ((c && c_n) || (c == k && c_n == k_n))
		else $error("output clock pair neither follows k nor stands high");
	k_period_a: assert property ($rose(k) |-> s_k_cycle)
		else $error("k half period is not four cycles");
	rd_frame_a: assert property ($fell(rd_sel_n) |-> s_sel_frame(rd_sel_n))
		else $error("read select frame wrong");
	wr_frame_a: assert property ($fell(wr_sel_n) |-> s_sel_frame(wr_sel_n))
		else $error("write select frame wrong");
	one_port_a: assert property (!(!rd_sel_n && !wr_sel_n))
		else $error("both selects low together");
	addr_hold_a: assert property ((!rd_sel_n || !wr_sel_n) && !$fell(rd_sel_n)
		&& !$fell(wr_sel_n) |-> $stable(burst_address_bus))
		else $error("address moved while a select was held");
	q_burst_a: assert property ($rose(q_oe) |-> s_burst)
		else $error("read burst shorter than four words");
	rd_latency_a: assert property ($fell(rd_sel_n) |-> ##[8:30] q_oe)
		else $error("read data did not appear in time");
	q_release_a: assert property (q_oe |-> since_rd_ff < 6'h30)
		else $error("read bus driven with no read pending");
	bw_window_a: assert property ((!byte_lane_low_write_enable_n
		|| !byte_lane_high_write_enable_n) |-> since_wr_ff <= 6'h14)
		else $error("byte enable low outside a write burst");
endmodule

// ---- sim/tb.sv ----
// Self-checking bench joining the controller end and the device end
`timescale 1ns/10ps
`include "bq_consts.svh"
module tb;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic single_clk = 1'b0;
	logic req_rd = 1'b0;
	logic req_wr = 1'b0;
	logic [`BQ_ADDR_W-1:0] req_addr = '0;
	logic [4*`BQ_WORD_W-1:0] req_wdata = '0;
	logic [7:0] req_bw_n = 8'hFF;
	logic req_ack;
	logic [4*`BQ_WORD_W-1:0] rd_data;
	logic rd_valid;
	logic rd_busy;
	logic wr_busy;
	logic single_clk_mode;
	int n_errors = 0;
	int checks = 0;
	int cycles = 0;
	bq_link_if link();
	bq_sram_ctl i_bq_sram_ctl (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .link(link),
		.single_clk(single_clk), .req_rd(req_rd), .req_wr(req_wr), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_bw_n(req_bw_n), .req_ack(req_ack), .rd_data(rd_data),
		.rd_valid(rd_valid));
	bq_sram_dev i_bq_sram_dev (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .link(link),
		.rd_busy(rd_busy), .wr_busy(wr_busy), .single_clk_mode(single_clk_mode));
	bq_link_asserts u_chk (.clk_sys(clk_sys), .nrst(nrst), .k(link.k), .k_n(link.k_n),
		.c(link.c), .c_n(link.c_n), .rd_sel_n(link.rd_sel_n), .wr_sel_n(link.wr_sel_n),
		.burst_address_bus(link.burst_address_bus),
		.byte_lane_low_write_enable_n(link.byte_lane_low_write_enable_n),
		.byte_lane_high_write_enable_n(link.byte_lane_high_write_enable_n),
		.d(link.d), .q(link.q), .q_oe(link.q_oe));
	always #(`BQ_CLK_NS / 2) clk_sys = ~clk_sys;
	// ==========================================
	// Shared tasks
	task automatic summarize();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic check(input logic [71:0] seen, input logic [71:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Old ack may still stand, so wait one edge before asking
	task automatic issue(input logic rd, input logic [16:0] a, input logic [71:0] wd,
		input logic [7:0] bw);
		int i;
		@(posedge clk_sys);
		#1;
		req_rd = rd;
		req_wr = !rd;
		req_addr = a;
		req_wdata = wd;
		req_bw_n = bw;
		for (i = 0; i < 40 && req_ack !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
		end
		req_rd = 1'b0;
		req_wr = 1'b0;
		check({71'h0, req_ack}, 72'h1);
	endtask
	task automatic read_word(input logic [16:0] a, output logic [71:0] data);
		int i;
		logic busy;
		busy = 1'b0;
		issue(1'b1, a, 72'h0, 8'hFF);
		for (i = 0; i < 80 && rd_valid !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
			busy = busy | rd_busy;
		end
		check({71'h0, busy}, 72'h1);
		data = rd_data;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_burst();
		logic [71:0] got;
		issue(1'b0, 17'h00100, 72'h123456789ABCDEF012, 8'h00);
		issue(1'b0, 17'h00101, 72'hFEDCBA987654321001, 8'h00);
		// First write still in the device while the second is taken
		check({71'h0, wr_busy}, 72'h1);
		read_word(17'h00100, got);
		check(got, 72'h123456789ABCDEF012);
		read_word(17'h00101, got);
		check(got, 72'hFEDCBA987654321001);
	endtask
	task automatic t_lanes();
		logic [71:0] got;
		logic [71:0] exp;
		logic [7:0] masks [2];
		logic [71:0] old_v;
		logic [71:0] new_v;
		int m;
		int j;
		masks[0] = 8'hAA;
		masks[1] = 8'h55;
		old_v = 72'h0F0F0F0F0F0F0F0F0F;
		new_v = 72'hA5A5A5A5A5A5A5A5A5;
		for (m = 0; m < 2; m++) begin
			issue(1'b0, 17'h00200 + 17'(m), old_v, 8'h00);
			issue(1'b0, 17'h00200 + 17'(m), new_v, masks[m]);
			for (j = 0; j < 4; j++) begin
				exp[j*18 +: 9] = masks[m][2*j] ? old_v[j*18 +: 9] : new_v[j*18 +: 9];
				exp[j*18+9 +: 9] = masks[m][2*j+1] ? old_v[j*18+9 +: 9] : new_v[j*18+9 +: 9];
			end
			read_word(17'h00200 + 17'(m), got);
			check(got, exp);
		end
	endtask
	// Read straight after a write must see the write register
	task automatic t_forward();
		logic [71:0] got;
		issue(1'b0, 17'h00300, 72'h111111111111111111, 8'h00);
		read_word(17'h00300, got);
		check(got, 72'h111111111111111111);
		issue(1'b0, 17'h00300, 72'h2468ACE013579BDF02, 8'h00);
		read_word(17'h00300, got);
		check(got, 72'h2468ACE013579BDF02);
	endtask
	// Mode pin changes only under reset, as it must stay static in use
	task automatic t_single();
		logic [71:0] got;
		@(posedge clk_sys);
		#1;
		nrst = 1'b0;
		single_clk = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		nrst = 1'b1;
		// Mode flag trails the pins by the synchroniser and its own flop
		repeat (4) @(posedge clk_sys);
		#1;
		check({71'h0, single_clk_mode}, 72'h1);
		read_word(17'h00100, got);
		check(got, 72'h123456789ABCDEF012);
	endtask
	// ==========================================
	// Main sequence and hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			summarize();
		end
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		#1;
		nrst = 1'b1;
		t_burst();
		t_lanes();
		t_forward();
		t_single();
		summarize();
	end
endmodule
